// [rtl/spisf_defines.vh]
`ifndef SPISF_DEFINES_VH
`define SPISF_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SPISF_OFS_CTRL 8'h00
`define SPISF_OFS_STATUS 8'h04
`define SPISF_OFS_DATA 8'h08
`define SPISF_OFS_IRQ_STATUS 8'h0c
`define SPISF_OFS_IRQ_MASK 8'h10

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define SPISF_CTRL_FIFO_MODE 0
`define SPISF_CTRL_FRAMED 1
`define SPISF_CTRL_ON 7
`define SPISF_CTRL_DIV_LSB 8
`define SPISF_CTRL_DIV_MSB 15
`define SPISF_CTRL_RESET 32'h0000_0000

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define SPISF_ST_RX_CNT_LSB 24
`define SPISF_ST_TX_CNT_LSB 16
`define SPISF_ST_FRAME_ERR 12
`define SPISF_ST_ACTIVITY 11
`define SPISF_ST_UNDERRUN 8
`define SPISF_ST_SHIFTER_EMPTY 7
`define SPISF_ST_RX_OVERFLOW 6
`define SPISF_ST_RX_EMPTY 5
`define SPISF_ST_TX_EMPTY 3
`define SPISF_ST_TX_FULL 1
`define SPISF_ST_RX_FULL 0

// ---------------------------------------------------------------
// interrupt event bits
// ---------------------------------------------------------------
`define SPISF_IRQ_RX_WORD 0
`define SPISF_IRQ_OVERFLOW 1
`define SPISF_IRQ_UNDERRUN 2
`define SPISF_IRQ_FRAME_ERR 3
`define SPISF_IRQ_RESET 4'h0

// ---------------------------------------------------------------
// buffer and response codes
// ---------------------------------------------------------------
`define SPISF_PTR_W 4
`define SPISF_DEPTH 16
`define SPISF_WORD_W 8
`define SPISF_RESP_OKAY 2'b00
`define SPISF_RESP_SLVERR 2'b10

`endif

// [rtl/spisf_shifter.v]
`include "spisf_defines.vh"

// serial engine: master, mode 0, eight bits msb first
module spisf_shifter
(
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire framed,
	input wire [7:0] div,
	input wire tx_avail,
	input wire [7:0] tx_word,
	output wire tx_pop,
	input wire miso,
	input wire fsync,
	output wire busy,
	output reg underrun,
	output reg frame_err,
	output reg rx_done,
	output reg [7:0] rx_word,
	output reg sclk,
	output reg mosi,
	output wire ss_n
);
	localparam ST_IDLE = 2'b01;
	localparam ST_SHIFT = 2'b10;

	reg [1:0] state;
	reg [7:0] sh;
	reg [7:0] div_cnt;
	reg [2:0] bits;
	reg fs_d;
	wire fs_rise;
	wire start;
	wire tick;

	// framed transfers wait for the peer's sync edge
	assign fs_rise = fsync & ~fs_d;
	assign start = state[0] & run & (framed ? fs_rise : tx_avail);
	assign tx_pop = start & tx_avail;
	assign tick = (div_cnt == div);
	assign busy = state[1];
	assign ss_n = ~state[1];

	// ---------------------------------------------------------------
	// transfer sequencing
	// ---------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_IDLE;
			sh <= 8'h00;
			div_cnt <= 8'h00;
			bits <= 3'h0;
			fs_d <= 1'b0;
			underrun <= 1'b0;
			frame_err <= 1'b0;
			rx_done <= 1'b0;
			rx_word <= 8'h00;
			sclk <= 1'b0;
			mosi <= 1'b0;
		end
		else
		begin
			fs_d <= fsync;
			// empty buffer at a frame start sends zeros
			underrun <= start & ~tx_avail;
			// sync edge in mid-word breaks the frame
			frame_err <= state[1] & framed & fs_rise;
			rx_done <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					sclk <= 1'b0;
					div_cnt <= 8'h00;
					bits <= 3'h0;
					if (start)
					begin
						sh <= tx_avail ? tx_word : 8'h00;
						mosi <= tx_avail ? tx_word[7] : 1'b0;
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
					if (!run)
					begin
						state <= ST_IDLE;
						sclk <= 1'b0;
					end
					else if (tick && !sclk)
					begin
						// rising edge samples the peer
						sclk <= 1'b1;
						sh <= {sh[6:0], miso};
					end
					else if (tick)
					begin
						// falling edge presents the next bit
						sclk <= 1'b0;
						mosi <= sh[7];
						bits <= bits + 3'h1;
						if (bits == 3'h7)
						begin
							state <= ST_IDLE;
							rx_done <= 1'b1;
							rx_word <= sh;
						end
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
endmodule

// [rtl/spisf_top.v]
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "spisf_defines.vh"

// How it works
// - rx_element_count in bits 28..24 gives the words held in the receive buffer.
// - tx_element_count in bits 20..16 gives the words held in the transmit buffer.
// - frame_error_flag at bit 12 is set by a framing error and cleared by software.
// - activity_flag at bit 11 is high while a serial transfer is in progress.
// - tx_underrun_flag at bit 8 is set when a framed transfer finds no data.
// - the underrun flag clears on module disable or on a written zero.
// - shifter_empty_flag at bit 7 is high while the shift register is idle.
// - rx_overflow_flag at bit 6 is set when a received word is dropped on a full buffer.
// - the overflow flag is set only by hardware and clears on disable or a written zero.
// - in fifo mode rx_fifo_empty_flag at bit 5 shows the receive pointers equal.
// - tx_buffer_empty_flag at bit 3 rises on a move to the shifter, falls on a data write.
// - in standard mode tx_buffer_full_flag at bit 1 follows one held transmit word.
// - in fifo mode the transmit full flag shows write pointer plus one at read pointer.
// - in standard mode rx_buffer_full_flag at bit 0 follows one held receive word.
// - in fifo mode the receive full flag shows write pointer plus one at read pointer.
// - unimplemented status bits read as zero.
module spisf_top
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire sclk,
	output wire mosi,
	output wire ss_n,
	input wire miso,
	input wire fsync,
	output wire irq
);
	localparam A_CTRL = 3'd0;
	localparam A_STATUS = 3'd1;
	localparam A_DATA = 3'd2;
	localparam A_IRQ_ST = 3'd3;
	localparam A_IRQ_MASK = 3'd4;
	localparam A_NONE = 3'd7;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	reg [31:0] ctrl;
	reg [3:0] irq_status;
	reg [3:0] irq_mask;
	reg frame_error_flag;
	reg tx_underrun_flag;
	reg rx_overflow_flag;
	reg [7:0] tx_mem [0:`SPISF_DEPTH-1];
	reg [7:0] rx_mem [0:`SPISF_DEPTH-1];
	reg [3:0] consumer_write_ptr;
	reg [3:0] shifter_read_ptr;
	reg [3:0] shifter_write_ptr;
	reg [3:0] consumer_read_ptr;
	reg aw_held;
	reg w_held;
	reg [7:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg [1:0] sync1;
	reg [1:0] sync2;
	reg [1:0] sync3;
	reg [1:0] pin_f;
	wire fifo_mode_enable;
	wire framed_mode_enable;
	wire module_on;
	wire [4:0] tx_element_count;
	wire [4:0] rx_element_count;
	wire tx_buffer_full_flag;
	wire rx_buffer_full_flag;
	wire tx_buffer_empty_flag;
	wire rx_fifo_empty_flag;
	wire activity_flag;
	wire shifter_empty_flag;
	wire do_write;
	wire rd_take;
	wire [2:0] wr_sel;
	wire [2:0] rd_sel;
	wire tx_push;
	wire tx_pop;
	wire rx_pop;
	wire rx_done;
	wire [7:0] rx_word;
	wire underrun_ev;
	wire frame_err_ev;
	wire overflow_ev;
	wire [3:0] irq_events;
	wire [3:0] agree;
	wire [31:0] status_word;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// register select, shared by read and write paths
	function [2:0] reg_sel;
		input [7:0] addr;
		begin
			if (addr == `SPISF_OFS_CTRL)
				reg_sel = A_CTRL;
			else if (addr == `SPISF_OFS_STATUS)
				reg_sel = A_STATUS;
			else if (addr == `SPISF_OFS_DATA)
				reg_sel = A_DATA;
			else if (addr == `SPISF_OFS_IRQ_STATUS)
				reg_sel = A_IRQ_ST;
			else if (addr == `SPISF_OFS_IRQ_MASK)
				reg_sel = A_IRQ_MASK;
			else
				reg_sel = A_NONE;
		end
	endfunction

	// element count of a ring from its two pointers
	function [4:0] ring_count;
		input [3:0] wp;
		input [3:0] rp;
		begin
			ring_count = {1'b0, wp - rp};
		end
	endfunction

	// ring is full when one more write would meet the reader
	function ring_full;
		input [3:0] wp;
		input [3:0] rp;
		begin
			ring_full = ((wp + 4'h1) == rp);
		end
	endfunction

	assign fifo_mode_enable = ctrl[`SPISF_CTRL_FIFO_MODE];
	assign framed_mode_enable = ctrl[`SPISF_CTRL_FRAMED];
	assign module_on = ctrl[`SPISF_CTRL_ON];

	// ---------------------------------------------------------------
	// pin synchronisers: miso, fsync
	// ---------------------------------------------------------------
	// a pin change counts once stages two and three agree
	assign agree = {2'b00, ~(sync2 ^ sync3)};
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= 2'b00;
			sync2 <= 2'b00;
			sync3 <= 2'b00;
			pin_f <= 2'b00;
		end
		else
		begin
			sync1 <= {fsync, miso};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_f <= (sync3 & agree[1:0]) | (pin_f & ~agree[1:0]);
		end
	end

	// ---------------------------------------------------------------
	// buffer flags
	// ---------------------------------------------------------------
	assign tx_element_count = ring_count(consumer_write_ptr,
		shifter_read_ptr);
	assign rx_element_count = ring_count(shifter_write_ptr,
		consumer_read_ptr);
	// standard mode holds a single word each way
	assign tx_buffer_full_flag = fifo_mode_enable ?
		ring_full(consumer_write_ptr, shifter_read_ptr) :
		(tx_element_count != 5'h00);
	assign rx_buffer_full_flag = fifo_mode_enable ?
		ring_full(shifter_write_ptr, consumer_read_ptr) :
		(rx_element_count != 5'h00);
	assign tx_buffer_empty_flag = (tx_element_count == 5'h00);
	assign rx_fifo_empty_flag =
		(consumer_read_ptr == shifter_write_ptr);
	assign shifter_empty_flag = ~activity_flag;

	// ---------------------------------------------------------------
	// register bus: write side
	// ---------------------------------------------------------------
	// one write at a time; neither half is accepted again until the response is taken
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign wr_sel = reg_sel(wr_addr);
	// a push onto a full buffer is dropped
	assign tx_push = do_write & (wr_sel == A_DATA) & wr_strb[0] &
		module_on & ~tx_buffer_full_flag;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPISF_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == A_NONE) ?
					`SPISF_RESP_SLVERR : `SPISF_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// control and mask registers
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= `SPISF_CTRL_RESET;
			irq_mask <= `SPISF_IRQ_RESET;
		end
		else if (do_write && wr_sel == A_CTRL)
		begin
			if (wr_strb[0])
				ctrl[7:0] <= wr_data[7:0] & 8'h83;
			if (wr_strb[1])
				ctrl[15:8] <= wr_data[15:8];
		end
		else if (do_write && wr_sel == A_IRQ_MASK && wr_strb[0])
			irq_mask <= wr_data[3:0];
	end

	// ---------------------------------------------------------------
	// serial engine
	// ---------------------------------------------------------------
	spisf_shifter u_shifter
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.run(module_on),
		.framed(framed_mode_enable),
		.div(ctrl[`SPISF_CTRL_DIV_MSB:`SPISF_CTRL_DIV_LSB]),
		.tx_avail(~tx_buffer_empty_flag),
		.tx_word(tx_mem[shifter_read_ptr]),
		.tx_pop(tx_pop),
		.miso(pin_f[0]),
		.fsync(pin_f[1]),
		.busy(activity_flag),
		.underrun(underrun_ev),
		.frame_err(frame_err_ev),
		.rx_done(rx_done),
		.rx_word(rx_word),
		.sclk(sclk),
		.mosi(mosi),
		.ss_n(ss_n)
	);

	// a finished word with no room is thrown away
	assign overflow_ev = rx_done & rx_buffer_full_flag;

	// ---------------------------------------------------------------
	// transmit and receive buffers
	// ---------------------------------------------------------------
	// disabling the module empties both buffers
	always @(posedge aclk)
	begin
		if (!aresetn || !module_on)
		begin
			consumer_write_ptr <= 4'h0;
			shifter_read_ptr <= 4'h0;
			shifter_write_ptr <= 4'h0;
			consumer_read_ptr <= 4'h0;
		end
		else
		begin
			if (tx_push)
				consumer_write_ptr <= consumer_write_ptr + 4'h1;
			if (tx_pop)
				shifter_read_ptr <= shifter_read_ptr + 4'h1;
			if (rx_done && !rx_buffer_full_flag)
				shifter_write_ptr <= shifter_write_ptr + 4'h1;
			if (rx_pop)
				consumer_read_ptr <= consumer_read_ptr + 4'h1;
		end
	end

	// storage needs no reset: pointers gate every read
	always @(posedge aclk)
	begin
		if (tx_push)
			tx_mem[consumer_write_ptr] <= wr_data[7:0];
		if (rx_done && !rx_buffer_full_flag)
			rx_mem[shifter_write_ptr] <= rx_word;
	end

	// ---------------------------------------------------------------
	// clearable error flags
	// ---------------------------------------------------------------
	// set beats clear; a written one leaves the flag alone
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frame_error_flag <= 1'b0;
			tx_underrun_flag <= 1'b0;
			rx_overflow_flag <= 1'b0;
		end
		else
		begin
			if (frame_err_ev)
				frame_error_flag <= 1'b1;
			else if (!module_on)
				frame_error_flag <= 1'b0;
			else if (do_write && wr_sel == A_STATUS && wr_strb[1] &&
				!wr_data[`SPISF_ST_FRAME_ERR])
				frame_error_flag <= 1'b0;
			if (underrun_ev)
				tx_underrun_flag <= 1'b1;
			else if (!module_on)
				tx_underrun_flag <= 1'b0;
			else if (do_write && wr_sel == A_STATUS && wr_strb[1] &&
				!wr_data[`SPISF_ST_UNDERRUN])
				tx_underrun_flag <= 1'b0;
			if (overflow_ev)
				rx_overflow_flag <= 1'b1;
			else if (!module_on)
				rx_overflow_flag <= 1'b0;
			else if (do_write && wr_sel == A_STATUS && wr_strb[0] &&
				!wr_data[`SPISF_ST_RX_OVERFLOW])
				rx_overflow_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	assign irq_events = {frame_err_ev, underrun_ev, overflow_ev, rx_done};
	// sticky bits, cleared by writing one; a new event wins
	always @(posedge aclk)
	begin
		if (!aresetn)
			irq_status <= `SPISF_IRQ_RESET;
		else if (do_write && wr_sel == A_IRQ_ST && wr_strb[0])
			irq_status <= (irq_status & ~wr_data[3:0]) | irq_events;
		else
			irq_status <= irq_status | irq_events;
	end
	assign irq = |(irq_status & irq_mask);

	// ---------------------------------------------------------------
	// register bus: read side
	// ---------------------------------------------------------------
	assign status_word = {3'b000, rx_element_count,
		3'b000, tx_element_count,
		3'b000, frame_error_flag, activity_flag,
		2'b00, tx_underrun_flag,
		shifter_empty_flag, rx_overflow_flag,
		rx_fifo_empty_flag, 1'b0, tx_buffer_empty_flag,
		1'b0, tx_buffer_full_flag, rx_buffer_full_flag};

	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign rd_sel = reg_sel(s_axi_araddr);
	// reading the data register takes the oldest received word
	assign rx_pop = rd_take & (rd_sel == A_DATA) &
		~rx_fifo_empty_flag;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SPISF_RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SPISF_RESP_OKAY;
			if (rd_sel == A_CTRL)
				s_axi_rdata <= ctrl;
			else if (rd_sel == A_STATUS)
				s_axi_rdata <= status_word;
			else if (rd_sel == A_DATA)
				s_axi_rdata <= rx_fifo_empty_flag ? 32'h0000_0000 :
					{24'h000000, rx_mem[consumer_read_ptr]};
			else if (rd_sel == A_IRQ_ST)
				s_axi_rdata <= {28'h0000000, irq_status};
			else if (rd_sel == A_IRQ_MASK)
				s_axi_rdata <= {28'h0000000, irq_mask};
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `SPISF_RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// [sim/spisf_props.sv]
`include "spisf_defines.vh"

// ------------------------------------------------------------
// bus and status checks on the top ports
// ------------------------------------------------------------
module spisf_props
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire ss_n
);
	timeunit 1ns;
	timeprecision 100ps;
	reg [7:0] rd_addr;
	reg [7:0] wr_addr;
	wire rd_map;
	wire wr_map;

	// address of the response in flight, so codes can be judged
	always @(posedge aclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
		if (s_axi_awvalid && s_axi_awready)
			wr_addr <= s_axi_awaddr;
	end
	// five word slots from zero
	assign rd_map = rd_addr <= 8'h10 && rd_addr[1:0] == 2'h0;
	assign wr_map = wr_addr <= 8'h10 && wr_addr[1:0] == 2'h0;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_aw_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	a_write_code: assert property (s_axi_bvalid |-> s_axi_bresp ==
		(wr_map ? `SPISF_RESP_OKAY : `SPISF_RESP_SLVERR))
		else $error("write response code wrong");
	a_read_error: assert property (s_axi_rvalid && !rd_map
		|-> s_axi_rresp == `SPISF_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	a_status_zeros: assert property (
		s_axi_rvalid && rd_addr == `SPISF_OFS_STATUS
		|-> (s_axi_rdata & 32'he0e0_e614) == 32'h0)
		else $error("unused status bits set");
	a_busy_shown: assert property (
		(s_ar_take and (s_axi_araddr == `SPISF_OFS_STATUS && !ss_n))
		|=> s_axi_rdata[11] && !s_axi_rdata[7])
		else $error("transfer not shown in status");
endmodule

bind spisf_top spisf_props u_props
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ss_n(ss_n)
);

// [sim/spisf_peer.sv]
// ------------------------------------------------------------
// serial peer: slave, mode 0, msb first
// ------------------------------------------------------------
module spisf_peer
(
	input wire aclk,
	input wire sclk,
	input wire mosi,
	input wire ss_n,
	input wire [7:0] reply,
	output logic miso,
	output logic fsync,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;

	// quiet lines at start
	initial
	begin
		miso = 1'h0;
		fsync = 1'h0;
		got = 8'h00;
		sh = 8'h00;
	end
	// first bit must be out before the first rising sample
	always @(negedge ss_n)
	begin
		miso <= reply[7];
		sh <= {reply[6:0], 1'h0};
	end
	// next bit on each falling edge
	always @(negedge sclk)
	begin
		if (!ss_n)
		begin
			miso <= sh[7];
			sh <= {sh[6:0], 1'h0};
		end
	end
	// no pull on the line: deselected shows the inverse
	always @(posedge ss_n)
		miso <= ~miso;
	// capture what the block sends
	always @(posedge sclk)
	begin
		if (!ss_n)
			got <= {got[6:0], mosi};
	end
	// held ten cycles so it survives the input filter
	task sync_pulse;
	begin
		@(posedge aclk);
		fsync <= 1'h1;
		repeat (10) @(posedge aclk);
		fsync <= 1'h0;
	end
	endtask
endmodule

// [sim/testbench.sv]
`include "spisf_defines.vh"

`define CHK(nm, e, g) \
	begin \
		n_checks = n_checks + 1; \
		if ((g) !== (e)) \
		begin \
			num_errors = num_errors + 1; \
			$display("unexpected %s exp %h got %h", nm, e, g); \
		end \
	end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [7:0] CT = `SPISF_OFS_CTRL;
	localparam [7:0] ST = `SPISF_OFS_STATUS;
	localparam [7:0] DA = `SPISF_OFS_DATA;
	localparam [7:0] IS = `SPISF_OFS_IRQ_STATUS;
	localparam [7:0] IM = `SPISF_OFS_IRQ_MASK;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [7:0] reply = 8'h00;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire sclk, mosi, ss_n, miso, fsync;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	wire [7:0] got;
	logic [31:0] rdat;
	logic [1:0] rresp_q;
	logic [1:0] bresp_q;
	integer num_errors = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer i;

	spisf_top u_dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sclk(sclk), .mosi(mosi), .ss_n(ss_n),
		.miso(miso), .fsync(fsync), .irq(irq)
	);
	spisf_peer u_peer
	(
		.aclk(aclk), .sclk(sclk), .mosi(mosi), .ss_n(ss_n),
		.reply(reply), .miso(miso), .fsync(fsync), .got(got)
	);

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task print_verdict;
	begin
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// both halves offered together, each dropped once taken
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		logic ad;
		logic dd;
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ad = 1'h0;
		dd = 1'h0;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			ad = ad | awready;
			dd = dd | wready;
			awvalid <= !ad;
			wvalid <= !dd;
		end
		while (!bvalid)
			@(posedge aclk);
		bresp_q = bresp;
		bready <= 1'h0;
	end
	endtask
	task rd(input [7:0] a);
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'h0;
		@(posedge aclk);
		while (!rvalid)
			@(posedge aclk);
		rdat = rdata;
		rresp_q = rresp;
		rready <= 1'h0;
	end
	endtask
	// poll status until masked bits match, bounded
	task wait_st(input [31:0] m, input [31:0] v);
		integer k;
	begin
		k = 0;
		rd(ST);
		while ((rdat & m) !== v && k < 500)
		begin
			rd(ST);
			k = k + 1;
		end
	end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rd(ST);
		`CHK("status", 32'h0000_00a8, rdat)
		rd(8'h20);
		`CHK("bad read", {`SPISF_RESP_SLVERR, 32'h0}, {rresp_q, rdat})
		wr(8'h24, 32'h1, 4'hf);
		`CHK("bad write", `SPISF_RESP_SLVERR, bresp_q)
		// standard mode, slow serial clock to outrun the filter
		wr(CT, 32'h0000_0780, 4'h3);
		wr(IM, 32'h3, 4'h1);
		reply <= 8'hc3;
		wr(DA, 32'h5a, 4'h1);
		wait_st(32'h1, 32'h1);
		`CHK("one word", 32'h0000_0089, rdat & 32'h0000_0989)
		`CHK("sent", 8'h5a, got)
		`CHK("irq", 1'h1, irq)
		// second word lands on a full buffer
		reply <= 8'h3c;
		wr(DA, 32'h11, 4'h1);
		wait_st(32'h40, 32'h40);
		rd(DA);
		`CHK("kept word", 32'h0000_00c3, rdat)
		rd(ST);
		`CHK("after pop", 32'h40, rdat & 32'h41)
		rd(IS);
		`CHK("events", 32'h3, rdat & 32'h3)
		wr(ST, 32'h40, 4'h1);
		rd(ST);
		`CHK("ovf kept", 32'h40, rdat & 32'h40)
		wr(ST, 32'h0, 4'h1);
		rd(ST);
		`CHK("ovf clear", 32'h0, rdat & 32'h40)
		wr(IM, 32'h0, 4'h1);
		`CHK("masked", 1'h0, irq)
		wr(IM, 32'h3, 4'h1);
		`CHK("unmasked", 1'h1, irq)
		wr(IS, 32'hf, 4'h1);
		`CHK("cleared", 1'h0, irq)
		// standard framed mode keeps one word until a sync arrives
		wr(CT, 32'h0000_0782, 4'h3);
		wr(DA, 32'h77, 4'h1);
		rd(ST);
		`CHK("tx held", 32'h2, rdat & 32'ha)
		wr(CT, 32'h0000_0702, 4'h3);
		// framed fifo mode holds words until a sync arrives
		wr(CT, 32'h0000_0783, 4'h3);
		for (i = 0; i < 16; i = i + 1)
			wr(DA, 32'h10 + i, 4'h1);
		rd(ST);
		`CHK("tx full", 32'h000f_0022, rdat & 32'h1f1f_002b)
		u_peer.sync_pulse();
		wait_st(32'h800, 32'h0);
		`CHK("frame", 32'h010e_0000, rdat & 32'h1f1f_0020)
		`CHK("frame word", 8'h10, got)
		u_peer.sync_pulse();
		repeat (20) @(posedge aclk);
		u_peer.sync_pulse();
		wait_st(32'h1800, 32'h1000);
		`CHK("frame err", 32'h1000, rdat & 32'h1000)
		wr(ST, 32'h1000, 4'h2);
		rd(ST);
		`CHK("ferr kept", 32'h1000, rdat & 32'h1000)
		wr(ST, 32'h0, 4'h2);
		rd(ST);
		`CHK("ferr clear", 32'h0, rdat & 32'h1000)
		// drain the rest so the receive ring fills up
		for (i = 0; i < 13; i = i + 1)
		begin
			u_peer.sync_pulse();
			wait_st(32'h800, 32'h0);
		end
		rd(ST);
		`CHK("rx ring full", 32'h0f00_0009, rdat & 32'h1f1f_002b)
		// off and on again flushes, so a sync finds nothing
		wr(CT, 32'h0000_0703, 4'h3);
		wr(CT, 32'h0000_0783, 4'h3);
		u_peer.sync_pulse();
		wait_st(32'h900, 32'h100);
		`CHK("underrun", 32'h108, rdat & 32'h108)
		wr(ST, 32'h0, 4'h2);
		rd(ST);
		`CHK("udr zero", 32'h0, rdat & 32'h100)
		u_peer.sync_pulse();
		wait_st(32'h900, 32'h100);
		wr(ST, 32'h100, 4'h2);
		rd(ST);
		`CHK("udr kept", 32'h100, rdat & 32'h100)
		wr(CT, 32'h0000_0703, 4'h3);
		wr(CT, 32'h0000_0783, 4'h3);
		rd(ST);
		`CHK("udr cycle", 32'h0, rdat & 32'h100)
		print_verdict;
	end
endmodule
